// ===== design/i2ra_host.sv
// master end: one two-byte register write or read per command,
// plus the update fifo that the slave end instantiates
// assumes: sole master, no clock stretching, clk_sys at 10 MHz
`timescale 1ns/10ps
`default_nettype none
`include "i2ra_defines.svh"

// ****************************************************************
// update fifo of the slave end
// ****************************************************************
module i2ra_fifo #(
  parameter int W = 24,
  parameter int D = `I2RA_FIFO_DEPTH
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  localparam logic [AW:0]   FULL = D[AW:0];
  localparam logic [AW-1:0] LAST = AW'(D - 1);

  logic [W-1:0]  mem_r   [D];
  logic [W-1:0]  mem_nxt [D];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0]   cnt_r, cnt_nxt;
  logic          push, pop;

  assign in_ready  = cnt_r != FULL;
  assign out_valid = cnt_r != '0;
  assign out_data  = mem_r[rp_r];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb begin
    mem_nxt = mem_r;
    wp_nxt  = wp_r;
    rp_nxt  = rp_r;
    cnt_nxt = cnt_r;
    if (push) begin
      mem_nxt[wp_r] = in_data;
      wp_nxt        = (wp_r == LAST) ? '0 : wp_r + 1'b1;
    end
    if (pop) begin
      rp_nxt = (rp_r == LAST) ? '0 : rp_r + 1'b1;
    end
    cnt_nxt = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
    mem_r <= mem_nxt;
  end
endmodule : i2ra_fifo

module i2ra_host #(
  parameter int QTR = `I2RA_QTR_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  i2ra_if.host             bus,
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  wire logic        cmd_rd,
  input  wire logic [7:0]  cmd_addr,
  input  wire logic [15:0] cmd_wdata,
  output logic             rsp_valid,
  output logic             rsp_nak,
  output logic [15:0]      rsp_rdata
);
  import i2ra_pkg::*;

  // ****************************************************************
  // sequencer state
  // ****************************************************************
  i2ra_host_st_t st_r, st_nxt, ns;
  logic [15:0] div_r, div_nxt;
  logic [1:0]  q_r, q_nxt;
  logic [2:0]  step_r, step_nxt;
  logic [3:0]  bit_r, bit_nxt;
  logic [7:0]  sh_r, sh_nxt, addr_r, addr_nxt;
  logic [15:0] wd_r, wd_nxt, rdat_r, rdat_nxt;
  logic        rd_r, rd_nxt, nak_r, nak_nxt, scl_r, scl_nxt, sda_r, sda_nxt;
  logic        rv_r, rv_nxt, tick, bitval;
  logic [7:0]  nbyte;
  logic [1:0]  qn;
  logic [1:0]  sda_s_r;

  // ****************************************************************
  // program of one command
  // ****************************************************************
  always_comb begin
    ns    = H_STOP;
    nbyte = 8'hff;
    case ({rd_r, step_r})
      4'h1, 4'h9, 4'hc: ns = H_TX;
      4'h2, 4'ha:       ns = H_TX;
      4'h3, 4'h4:       ns = H_TX;
      4'hb:             ns = H_START;
      4'hd, 4'he:       ns = H_RX;
      default:          ns = H_STOP;
    endcase
    case ({rd_r, step_r})
      4'h1, 4'h9: nbyte = {`I2RA_SLAVE_ID, 1'b0};
      4'hc:       nbyte = {`I2RA_SLAVE_ID, 1'b1};
      4'h2, 4'ha: nbyte = addr_r;
      4'h3:       nbyte = wd_r[15:8];
      4'h4:       nbyte = wd_r[7:0];
      default:    nbyte = 8'hff;
    endcase
  end

  assign tick      = div_r == 16'(QTR - 1);
  assign cmd_ready = st_r == H_IDLE;
  assign rsp_valid = rv_r;
  assign rsp_nak   = nak_r;
  assign rsp_rdata = rdat_r;
  assign bus.scl_h_o    = 1'b0;
  assign bus.scl_h_oe_n = scl_r;
  assign bus.sda_h_o    = 1'b0;
  assign bus.sda_h_oe_n = sda_r;

  // value of the coming bit, set while scl is low; last rx byte gets a nak
  assign bitval = (bit_nxt == `I2RA_BYTE_BITS) ?
                  ((st_nxt == H_RX) ? (step_r == 3'h7) : 1'b1) :
                  ((st_nxt == H_TX) ? sh_nxt[7] : 1'b1);

  always_comb begin
    st_nxt   = st_r;
    div_nxt  = div_r;
    q_nxt    = q_r;
    step_nxt = step_r;
    bit_nxt  = bit_r;
    sh_nxt   = sh_r;
    addr_nxt = addr_r;
    wd_nxt   = wd_r;
    rdat_nxt = rdat_r;
    rd_nxt   = rd_r;
    nak_nxt  = nak_r;
    scl_nxt  = scl_r;
    sda_nxt  = sda_r;
    rv_nxt   = 1'b0;
    qn       = q_r + 2'h1;
    if (st_r == H_IDLE) begin
      scl_nxt = 1'b1;
      sda_nxt = 1'b1;
      if (cmd_valid) begin
        st_nxt   = H_START;
        rd_nxt   = cmd_rd;
        addr_nxt = cmd_addr;
        wd_nxt   = cmd_wdata;
        nak_nxt  = 1'b0;
        step_nxt = 3'h1;
        div_nxt  = 16'h0;
        q_nxt    = 2'h0;
        scl_nxt  = 1'b0;
      end
    end else if (!tick) begin
      div_nxt = div_r + 16'h1;
    end else begin
      div_nxt = 16'h0;
      q_nxt   = qn;
      if (q_r == 2'h1 && (st_r == H_TX || st_r == H_RX)) begin
        if (bit_r == `I2RA_BYTE_BITS) begin
          nak_nxt = nak_r | (st_r == H_TX && sda_s_r[1]);
        end else if (st_r == H_RX) begin
          sh_nxt = {sh_r[6:0], sda_s_r[1]};
        end
      end
      if (q_r == 2'h3) begin
        case (st_r)
          H_START: begin
            st_nxt   = ns;
            bit_nxt  = 4'h0;
            sh_nxt   = nbyte;
            step_nxt = step_r + 3'h1;
          end
          H_TX, H_RX: begin
            if (bit_r != `I2RA_BYTE_BITS) begin
              bit_nxt = bit_r + 4'h1;
              if (st_r == H_TX) begin
                sh_nxt = {sh_r[6:0], 1'b1};
              end
            end else begin
              if (st_r == H_RX) begin
                rdat_nxt = {rdat_r[7:0], sh_r};
              end
              st_nxt   = nak_r ? H_STOP : ns;
              bit_nxt  = 4'h0;
              sh_nxt   = nbyte;
              step_nxt = step_r + 3'h1;
            end
          end
          H_STOP: begin
            st_nxt = H_IDLE;
            rv_nxt = 1'b1;
          end
          default: st_nxt = H_IDLE;
        endcase
      end
      case (st_nxt)
        H_START: begin
          scl_nxt = qn[0] ^ qn[1];
          sda_nxt = ~qn[1];
        end
        H_STOP: begin
          scl_nxt = qn != 2'h0;
          sda_nxt = qn[1];
        end
        H_TX, H_RX: begin
          scl_nxt = qn[0] ^ qn[1];
          sda_nxt = bitval;
        end
        default: begin
          scl_nxt = 1'b1;
          sda_nxt = 1'b1;
        end
      endcase
    end
  end

  // ****************************************************************
  // registers and sda synchroniser
  // ****************************************************************

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sda_s_r <= 2'h3;
      st_r    <= H_IDLE;
      div_r   <= 16'h0;
      q_r     <= 2'h0;
      step_r  <= 3'h0;
      bit_r   <= 4'h0;
      sh_r    <= 8'h00;
      addr_r  <= 8'h00;
      wd_r    <= 16'h0;
      rdat_r  <= 16'h0;
      rd_r    <= 1'b0;
      nak_r   <= 1'b0;
      scl_r   <= 1'b1;
      sda_r   <= 1'b1;
      rv_r    <= 1'b0;
    end else begin
      sda_s_r <= {sda_s_r[0], bus.sda};
      st_r    <= st_nxt;
      div_r   <= div_nxt;
      q_r     <= q_nxt;
      step_r  <= step_nxt;
      bit_r   <= bit_nxt;
      sh_r    <= sh_nxt;
      addr_r  <= addr_nxt;
      wd_r    <= wd_nxt;
      rdat_r  <= rdat_nxt;
      rd_r    <= rd_nxt;
      nak_r   <= nak_nxt;
      scl_r   <= scl_nxt;
      sda_r   <= sda_nxt;
      rv_r    <= rv_nxt;
    end
  end
endmodule : i2ra_host

`default_nettype wire

// ===== inc/i2ra_defines.svh
// constants of the two-wire register access block
// assumes: included by bare name from the package and both ends
`ifndef I2RA_DEFINES_SVH
`define I2RA_DEFINES_SVH

// ****************************************************************
// bus identity and memory map
// ****************************************************************
`define I2RA_SLAVE_ID      7'h36
`define I2RA_WR_TOP        8'h4f
`define I2RA_RO_LAST       8'h07
`define I2RA_MEM_DEPTH     80
`define I2RA_OVF_BYTE      8'hff
`define I2RA_RSV_BYTE      8'h00
`define I2RA_PTR_MAX       8'hff
`define I2RA_BYTE_BITS     4'h8

// ****************************************************************
// buffering and timing
// ****************************************************************
`define I2RA_FIFO_DEPTH    8
`define I2RA_CLK_PERIOD_NS 100
`define I2RA_SCL_PERIOD_NS 10000
`define I2RA_QTR_CYC       (`I2RA_SCL_PERIOD_NS / (4 * `I2RA_CLK_PERIOD_NS))

`endif

// ===== inc/i2ra_pkg.sv
// types shared by both ends of the two-wire register access block
// assumes: i2ra_defines.svh sits on the include path
`include "i2ra_defines.svh"

package i2ra_pkg;

  // ****************************************************************
  // state machines
  // ****************************************************************
  typedef enum logic [2:0] {
    D_IDLE  = 3'h0,
    D_ID    = 3'h1,
    D_PTR   = 3'h3,
    D_WDATA = 3'h2,
    D_ACK   = 3'h6,
    D_RDATA = 3'h7,
    D_MACK  = 3'h5
  } i2ra_dev_st_t;

  typedef enum logic [2:0] {
    H_IDLE  = 3'h0,
    H_START = 3'h1,
    H_TX    = 3'h3,
    H_RX    = 3'h2,
    H_STOP  = 3'h6
  } i2ra_host_st_t;

  // ****************************************************************
  // committed register update
  // ****************************************************************
  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] data;
  } i2ra_upd_t;

endpackage : i2ra_pkg

// ===== inc/i2ra_if.sv
// two-wire bus between master end and slave end
// assumes: pull-ups modelled as a released line reading high
`timescale 1ns/10ps
`default_nettype none

interface i2ra_if;
  logic scl_h_o;
  logic scl_h_oe_n;
  logic sda_h_o;
  logic sda_h_oe_n;
  logic sda_d_o;
  logic sda_d_oe_n;
  wire  scl;
  wire  sda;

  // ****************************************************************
  // wired-and resolution
  // ****************************************************************
  assign scl = scl_h_oe_n | scl_h_o;
  assign sda = (sda_h_oe_n | sda_h_o) & (sda_d_oe_n | sda_d_o);

  modport host (output scl_h_o, scl_h_oe_n, sda_h_o, sda_h_oe_n, input scl, sda);
  modport dev  (output sda_d_o, sda_d_oe_n, input scl, sda);
endinterface : i2ra_if

`default_nettype wire

// ===== design/i2ra_dev.sv
// slave end: register read/write engine feeding an update fifo
// assumes: scl/sda come asynchronously from the bus, one clk_sys domain
// assumes: i2ra_fifo is compiled from the master end file
// Function
// - write stores bytes at ascending locations
// - master ends write after final acknowledge
// - data accepted straight after pointer acknowledge
// - pointer steps after each written byte
// - writes above 4Fh discarded
// - register written only with both bytes
// - read-only locations never written
// - cut or unacknowledged bytes never committed
// - master reads both register bytes together
// - read: pointer write, repeated start, read
// - msb first, pointer steps, next byte
// - past FFh reads return FFh
// - reserved locations return no guaranteed value
// - master ends read with nak, stop
// - answer only slave id 6Ch/6Dh
// - ack low on ninth clock
// - msb at even, lsb odd location
`timescale 1ns/10ps
`default_nettype none
`include "i2ra_defines.svh"

module i2ra_dev #(
  parameter int DEPTH = `I2RA_MEM_DEPTH
) (
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  i2ra_if.dev                    bus,
  input  wire logic              gauge_we,
  input  wire logic [7:0]        gauge_addr,
  input  wire logic [7:0]        gauge_data,
  output logic                   upd_valid,
  input  wire logic              upd_ready,
  output var i2ra_pkg::i2ra_upd_t upd_word
);
  import i2ra_pkg::*;
  localparam int AW = $clog2(DEPTH);

  // ****************************************************************
  // pin synchronisers and bus events
  // ****************************************************************
  logic [2:0] scl_s_r, sda_s_r;
  logic       scl_rise, scl_fall, bus_start, bus_stop;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      scl_s_r <= 3'h7;
      sda_s_r <= 3'h7;
    end else begin
      scl_s_r <= {scl_s_r[1:0], bus.scl};
      sda_s_r <= {sda_s_r[1:0], bus.sda};
    end
  end

  // only stages 1 and 2 feed logic; stage 0 is metastable
  assign scl_rise  = scl_s_r[1] & ~scl_s_r[2];
  assign scl_fall  = ~scl_s_r[1] & scl_s_r[2];
  assign bus_start = scl_s_r[1] & scl_s_r[2] & sda_s_r[2] & ~sda_s_r[1];
  assign bus_stop  = scl_s_r[1] & scl_s_r[2] & ~sda_s_r[2] & sda_s_r[1];

  // ****************************************************************
  // protocol engine
  // ****************************************************************
  i2ra_dev_st_t st_r, st_nxt, aft_r, aft_nxt;
  logic [3:0]   cnt_r, cnt_nxt;
  logic [7:0]   sh_r, sh_nxt, ptr_r, ptr_nxt, tgt_r, tgt_nxt, hi_r, hi_nxt;
  logic         ovf_r, ovf_nxt, oe_n_r, oe_n_nxt, mack_r, mack_nxt;
  logic         ph_r, ph_nxt, cm_r, cm_nxt, pend_r, pend_nxt;
  logic [7:0]   mem_r   [DEPTH];
  logic [7:0]   mem_nxt [DEPTH];
  logic [7:0]   rd_byte;
  logic         wok, push, fifo_rdy;
  logic [AW-1:0] even_ix;

  assign bus.sda_d_o    = 1'b0;
  assign bus.sda_d_oe_n = oe_n_r;
  assign even_ix        = {tgt_r[AW-1:1], 1'b0};
  assign wok            = !ovf_r && (ptr_r <= `I2RA_WR_TOP) && (ptr_r > `I2RA_RO_LAST);

  always_comb begin
    rd_byte = `I2RA_RSV_BYTE;
    if (ovf_r) begin
      rd_byte = `I2RA_OVF_BYTE;
    end else if (ptr_r <= `I2RA_WR_TOP) begin
      rd_byte = mem_r[ptr_r[AW-1:0]];
    end
  end

  always_comb begin
    st_nxt   = st_r;
    aft_nxt  = aft_r;
    cnt_nxt  = cnt_r;
    sh_nxt   = sh_r;
    ptr_nxt  = ptr_r;
    tgt_nxt  = tgt_r;
    hi_nxt   = hi_r;
    ovf_nxt  = ovf_r;
    oe_n_nxt = oe_n_r;
    mack_nxt = mack_r;
    ph_nxt   = ph_r;
    cm_nxt   = cm_r;
    pend_nxt = pend_r;
    mem_nxt  = mem_r;
    push     = 1'b0;
    if (gauge_we && gauge_addr <= `I2RA_WR_TOP) begin
      mem_nxt[gauge_addr[AW-1:0]] = gauge_data;
    end
    if (bus_start) begin
      st_nxt   = D_ID;
      cnt_nxt  = 4'h0;
      oe_n_nxt = 1'b1;
      pend_nxt = 1'b0;
    end else if (bus_stop) begin
      st_nxt   = D_IDLE;
      oe_n_nxt = 1'b1;
      pend_nxt = 1'b0;
    end else begin
      case (st_r)
        D_ID, D_PTR, D_WDATA: begin
          if (scl_rise && cnt_r != `I2RA_BYTE_BITS) begin
            sh_nxt  = {sh_r[6:0], sda_s_r[1]};
            cnt_nxt = cnt_r + 4'h1;
          end else if (scl_fall && cnt_r == `I2RA_BYTE_BITS) begin
            cnt_nxt  = 4'h0;
            st_nxt   = D_ACK;
            oe_n_nxt = 1'b0;
            ph_nxt   = 1'b0;
            cm_nxt   = 1'b0;
            aft_nxt  = D_WDATA;
            if (st_r == D_ID) begin
              aft_nxt = sh_r[0] ? D_RDATA : D_PTR;
              if (sh_r[7:1] != `I2RA_SLAVE_ID) begin
                st_nxt   = D_IDLE;
                oe_n_nxt = 1'b1;
              end
            end else if (st_r == D_PTR) begin
              ptr_nxt = sh_r;
              ovf_nxt = 1'b0;
            end else begin
              tgt_nxt = ptr_r;
              ph_nxt  = wok & ~ptr_r[0];
              cm_nxt  = wok & ptr_r[0] & pend_r;
              // a full fifo refuses the pair by nak rather than losing it
              if (wok && ptr_r[0] && pend_r && !fifo_rdy) begin
                oe_n_nxt = 1'b1;
              end
              ptr_nxt = ptr_r + 8'h1;
              ovf_nxt = ovf_r | (ptr_r == `I2RA_PTR_MAX);
            end
          end
        end
        D_ACK: begin
          if (scl_fall) begin
            oe_n_nxt = 1'b1;
            cnt_nxt  = 4'h0;
            st_nxt   = aft_r;
            pend_nxt = 1'b0;
            if (oe_n_r) begin
              st_nxt = D_IDLE;
            end else if (aft_r == D_RDATA) begin
              sh_nxt   = rd_byte;
              oe_n_nxt = rd_byte[7];
            end else begin
              if (ph_r) begin
                hi_nxt   = sh_r;
                pend_nxt = 1'b1;
              end
              if (cm_r) begin
                mem_nxt[even_ix]            = hi_r;
                mem_nxt[tgt_r[AW-1:0]]      = sh_r;
                push                        = 1'b1;
              end
            end
          end
        end
        D_RDATA: begin
          if (scl_rise) begin
            cnt_nxt = cnt_r + 4'h1;
          end else if (scl_fall) begin
            if (cnt_r == `I2RA_BYTE_BITS) begin
              oe_n_nxt = 1'b1;
              st_nxt   = D_MACK;
              ptr_nxt  = ptr_r + 8'h1;
              ovf_nxt  = ovf_r | (ptr_r == `I2RA_PTR_MAX);
            end else begin
              sh_nxt   = {sh_r[6:0], 1'b1};
              oe_n_nxt = sh_r[6];
            end
          end
        end
        D_MACK: begin
          if (scl_rise) begin
            mack_nxt = ~sda_s_r[1];
          end else if (scl_fall) begin
            cnt_nxt = 4'h0;
            if (mack_r) begin
              st_nxt   = D_RDATA;
              sh_nxt   = rd_byte;
              oe_n_nxt = rd_byte[7];
            end else begin
              st_nxt = D_IDLE;
            end
          end
        end
        default: begin
          st_nxt   = D_IDLE;
          oe_n_nxt = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_r   <= D_IDLE;
      aft_r  <= D_IDLE;
      cnt_r  <= 4'h0;
      sh_r   <= 8'h00;
      ptr_r  <= 8'h00;
      tgt_r  <= 8'h00;
      hi_r   <= 8'h00;
      ovf_r  <= 1'b0;
      oe_n_r <= 1'b1;
      mack_r <= 1'b0;
      ph_r   <= 1'b0;
      cm_r   <= 1'b0;
      pend_r <= 1'b0;
      mem_r  <= '{default: 8'h00};
    end else begin
      st_r   <= st_nxt;
      aft_r  <= aft_nxt;
      cnt_r  <= cnt_nxt;
      sh_r   <= sh_nxt;
      ptr_r  <= ptr_nxt;
      tgt_r  <= tgt_nxt;
      hi_r   <= hi_nxt;
      ovf_r  <= ovf_nxt;
      oe_n_r <= oe_n_nxt;
      mack_r <= mack_nxt;
      ph_r   <= ph_nxt;
      cm_r   <= cm_nxt;
      pend_r <= pend_nxt;
      mem_r  <= mem_nxt;
    end
  end

  // ****************************************************************
  // committed register updates toward the gauge logic
  // ****************************************************************
  i2ra_fifo #(
    .W ($bits(i2ra_upd_t)),
    .D (`I2RA_FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .in_valid  (push),
    .in_ready  (fifo_rdy),
    .in_data   ({{tgt_r[7:1], 1'b0}, hi_r, sh_r}),
    .out_valid (upd_valid),
    .out_ready (upd_ready),
    .out_data  (upd_word)
  );
endmodule : i2ra_dev

`default_nettype wire

// ===== tb/i2ra_monitor.sv
// wire-level checks of the device end of the two-wire bus
// assumes: signals of one i2ra_if, one clk_sys domain
`timescale 1ns/10ps
`default_nettype none

module i2ra_monitor #(
  parameter int QTR = 4
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic sda_h_oe_n,
  input wire logic sda_d_o,
  input wire logic sda_d_oe_n,
  input wire logic scl,
  input wire logic sda
);
  // ********************
  // helper logic
  // ********************
  localparam int LIM = 40 * QTR;
  logic [9:0] low_cnt_r;
  logic [9:0] low_cnt_nxt;

  // ack plus eight zero bits is the longest legal pull
  always_comb low_cnt_nxt = sda_d_oe_n ? 10'h000 : low_cnt_r + 10'h001;
  always_ff @(posedge clk_sys) low_cnt_r <= !rst_n ? 10'h000 : low_cnt_nxt;

  // ********************
  // properties
  // ********************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_start;
    scl && $fell(sda);
  endsequence
  sequence s_stop;
    scl && $rose(sda);
  endsequence

  a_open_drain_low: assert property (sda_d_o == 1'b0)
    else $error("device drives sda high");
  a_quiet_start: assert property (s_start |=> sda_d_oe_n [*8])
    else $error("device drives sda during slave id");
  a_stop_release: assert property (s_stop |=> sda_d_oe_n [*8])
    else $error("device drives sda after stop");
  a_turn_on_low: assert property ($fell(sda_d_oe_n) |-> !scl)
    else $error("device takes sda while scl high");
  a_turn_off_low: assert property ($rose(sda_d_oe_n) |-> !scl)
    else $error("device releases sda while scl high");
  a_ack_width: assert property ($fell(sda_d_oe_n) |-> !sda_d_oe_n [*8])
    else $error("device low bit too short");
  a_low_bounded: assert property (low_cnt_r < LIM)
    else $error("device holds sda low too long");
  a_host_rel_ack: assert property ((scl && !sda_d_oe_n) |-> sda_h_oe_n)
    else $error("both ends drive sda");
endmodule : i2ra_monitor

`default_nettype wire

// ===== tb/i2ra_bench.sv
// bench: master end and slave end joined by one interface
// assumes: design files, package and interface compiled first
`timescale 1ns/10ps
`default_nettype none

module i2ra_bench;
  import i2ra_pkg::*;
  localparam int QTR = 4;
  logic       clk_sys, rst_n, cmd_valid, cmd_ready, cmd_rd, rsp_valid, rsp_nak;
  logic       gauge_we, upd_valid, upd_ready;
  logic [7:0] cmd_addr, gauge_addr, gauge_data;
  logic [15:0] cmd_wdata, rsp_rdata;
  i2ra_upd_t  upd_word;
  int         errors, check_count, i;

  i2ra_if i2ra_bus();
  i2ra_host #(.QTR(QTR)) i2ra_host_inst (.clk_sys(clk_sys), .rst_n(rst_n), .bus(i2ra_bus),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_rd(cmd_rd), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_nak(rsp_nak), .rsp_rdata(rsp_rdata));
  i2ra_dev i2ra_dev_inst (.clk_sys(clk_sys), .rst_n(rst_n), .bus(i2ra_bus),
    .gauge_we(gauge_we), .gauge_addr(gauge_addr), .gauge_data(gauge_data),
    .upd_valid(upd_valid), .upd_ready(upd_ready), .upd_word(upd_word));
  i2ra_monitor #(.QTR(QTR)) i2ra_monitor_inst (.clk_sys(clk_sys), .rst_n(rst_n),
    .sda_h_oe_n(i2ra_bus.sda_h_oe_n), .sda_d_o(i2ra_bus.sda_d_o),
    .sda_d_oe_n(i2ra_bus.sda_d_oe_n), .scl(i2ra_bus.scl), .sda(i2ra_bus.sda));

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // ********************
  // tasks
  // ********************
  task automatic end_sim();
    if (errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim

  task automatic chk(input string name, input logic [23:0] seen, input logic [23:0] exp);
    check_count++;
    if (seen !== exp) begin
      $display("wrong value %s expected %h seen %h", name, exp, seen);
      errors++;
    end
  endtask : chk

  // one command; the whole transfer ends with the rsp_valid pulse
  task automatic xfer(input logic rd, input logic [7:0] a, input logic [15:0] d);
    int n;
    cmd_rd = rd;
    cmd_addr = a;
    cmd_wdata = d;
    chk("cmd ready", cmd_ready, 1'b1);
    cmd_valid = 1'b1;
    @(posedge clk_sys);
    #1 cmd_valid = 1'b0;
    chk("cmd busy", cmd_ready, 1'b0);
    for (n = 0; n < 3000 && rsp_valid !== 1'b1; n++) begin
      @(posedge clk_sys);
      #1;
    end
    if (n == 3000) begin
      errors++;
      end_sim();
    end
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic nak);
    xfer(1'b0, a, d);
    chk("write nak", rsp_nak, nak);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [15:0] d);
    xfer(1'b1, a, 16'h0000);
    chk("read nak", rsp_nak, 1'b0);
    chk("read data", rsp_rdata, d);
  endtask : rd

  // extra idle edge so ready is never set twice in one step
  task automatic pop(input logic [23:0] w);
    chk("upd valid", upd_valid, 1'b1);
    chk("upd word", upd_word, w);
    upd_ready = 1'b1;
    @(posedge clk_sys);
    #1 upd_ready = 1'b0;
    @(posedge clk_sys);
    #1;
  endtask : pop

  // ********************
  // sequence of tests
  // ********************
  initial begin
    {rst_n, cmd_valid, cmd_rd, gauge_we, upd_ready} = 5'h00;
    {cmd_addr, gauge_addr, gauge_data, cmd_wdata} = 40'h0;
    errors = 0;
    check_count = 0;
    repeat (3) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    wr(8'h0a, 16'h1234, 1'b0);
    pop({8'h0a, 16'h1234});
    rd(8'h0a, 16'h1234);
    wr(8'h04, 16'ha55a, 1'b0);
    rd(8'h04, 16'h0000);
    {gauge_we, gauge_addr, gauge_data} = {1'b1, 8'h02, 8'hc3};
    @(posedge clk_sys);
    #1 gauge_we = 1'b0;
    rd(8'h02, 16'hc300);
    wr(8'h4e, 16'hbeef, 1'b0);
    pop({8'h4e, 16'hbeef});
    wr(8'h50, 16'h1111, 1'b0);
    rd(8'h4e, 16'hbeef);
    rd(8'h50, 16'h0000);
    rd(8'hff, 16'h00ff);
    wr(8'h0b, 16'h7788, 1'b0);
    rd(8'h0a, 16'h1234);
    rd(8'h0c, 16'h0000);
    chk("upd valid", upd_valid, 1'b0);
    // fill the update buffer until the device refuses a pair
    for (i = 0; i < 8; i++) wr(8'h10 + 8'(2 * i), {i[7:0], ~i[7:0]}, 1'b0);
    wr(8'h30, 16'h5555, 1'b1);
    rd(8'h30, 16'h0000);
    for (i = 0; i < 8; i++) pop({8'h10 + 8'(2 * i), i[7:0], ~i[7:0]});
    chk("upd valid", upd_valid, 1'b0);
    end_sim();
  end
endmodule : i2ra_bench

`default_nettype wire
